// ---- shared/serdes_lane_regs_defs.svh ----
// Constants of the lane polarity, equalizer and status overlay register pair.
// Assumes inclusion by the package and by design files that need offsets.
`ifndef SERDES_LANE_REGS_DEFS_SVH
`define SERDES_LANE_REGS_DEFS_SVH

`define MGMT_DEVICE_ADDR       5'h1e
`define LANE_CTL_OFFSET        16'h0008
`define OVERLAY_CTL_OFFSET     16'h0009
`define LANE_CTL_RESET         16'h000d
`define OVERLAY_CTL_RESET      16'h0380
`define OVERLAY_READ_MASK      16'hffbf
`define LANE_RX_SWAP_BIT       15
`define LANE_TX_SWAP_BIT       14
`define LANE_EQ_MSB            11
`define LANE_EQ_LSB            8
`define OVL_OUT_GATE_MSB       15
`define OVL_OUT_GATE_LSB       14
`define OVL_IN_GATE_MSB        13
`define OVL_IN_GATE_LSB        12
`define OVL_LOS_MASK_BIT       7
`define OVL_ENABLE_MSB         5
`define EQ_MAX_GAIN            4'h0
`define EQ_ADAPTIVE            4'h1
`define EQ_STEPPED_FIRST       4'h8
`define MDIO_PREAMBLE_BITS     32
`define MDIO_START             2'h0
`define MDIO_OP_ADDRESS        2'h0
`define MDIO_OP_WRITE          2'h1

`endif

// ---- shared/serdes_lane_regs_pkg.sv ----
// Types shared by the management frame engine and the register bank.
// Assumes the constants header sits on the include path.
`include "serdes_lane_regs_defs.svh"

package serdes_lane_regs_pkg;

  typedef enum logic [1:0] {
    S_PREAMBLE = 2'b00,
    S_HEADER   = 2'b01,
    S_TURN     = 2'b10,
    S_DATA     = 2'b11
  } mdio_state_e;

  typedef struct packed {
    logic        mdc_s1;
    logic        mdc_s2;
    logic        mdc_s3;
    logic        mdio_s1;
    logic        mdio_s2;
    mdio_state_e state;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic [1:0]  op;
    logic [15:0] shift;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        mdio_out;
    logic        mdio_drive_n;
  } mdio_frame_s;

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [15:0] lane_ctl;
    logic [15:0] overlay_ctl;
    logic        rx_lane_polarity_swap;
    logic        tx_lane_polarity_swap;
    logic [3:0]  lane_equalizer_setting;
    logic        lane_equalizer_adaptive;
    logic        lane_equalizer_reserved;
    logic        rx_lane_out_positive;
    logic        tx_lane_data;
    logic        lane_ready_out_pin;
    logic        lane_ready_in_gated;
    logic        channel_sync_ok;
    logic        fault_indicator_pin;
  } bank_state_s;

endpackage

// ---- shared/mgmt_reg_if.sv ----
// Word access path from the management frame engine to the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface mgmt_reg_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic [15:0] rdata;

  modport engine (output addr, output wdata, output wr, input rdata);
  modport bank   (input addr, input wdata, input wr, output rdata);
endinterface

// ---- rtl/mdio_frame_engine.sv ----
// Management serial frame engine: indirect-address frames for one device address.
// Assumes mdc and mdio_in arrive asynchronously and mdc is far slower than ref_clk.
`timescale 1ns/10ps
`include "serdes_lane_regs_defs.svh"

module mdio_frame_engine
  import serdes_lane_regs_pkg::*;
#(
  parameter logic [4:0] PORT_ADDR     = 5'h00,
  parameter int         PREAMBLE_BITS = `MDIO_PREAMBLE_BITS
) (
  input  wire logic    ref_clk,
  input  wire logic    rstn,
  input  wire logic    mdc,
  input  wire logic    mdio_in,
  output logic         mdio_out,
  output logic         mdio_drive_n,
  mgmt_reg_if.engine   bus
);

  if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 62) begin : g_bad_preamble
    $error("PREAMBLE_BITS must lie between 1 and 62.");
  end

  mdio_frame_s r;
  mdio_frame_s n;

  always_comb begin
    logic        rise;
    logic        bit_in;
    logic [15:0] shifted;
    rise    = r.mdc_s2 & ~r.mdc_s3;
    bit_in  = r.mdio_s2;
    shifted = {r.shift[14:0], bit_in};
    n         = r;
    n.mdc_s1  = mdc;
    n.mdc_s2  = r.mdc_s1;
    n.mdc_s3  = r.mdc_s2;
    n.mdio_s1 = mdio_in;
    n.mdio_s2 = r.mdio_s1;
    n.wr      = 1'b0;
    case (r.state)
      S_PREAMBLE: if (rise) begin
        if (bit_in) begin
          if (r.ones != 6'h3f) n.ones = r.ones + 6'h01;
        end else if (r.ones >= 6'(PREAMBLE_BITS)) begin
          n.state = S_HEADER;
          n.cnt   = 5'h01;
          n.shift = 16'h0000;
        end else begin
          n.ones = 6'h00;
        end
      end
      S_HEADER: if (rise) begin
        n.shift = shifted;
        n.cnt   = r.cnt + 5'h01;
        if (r.cnt == 5'h0d) begin
          n.op  = shifted[11:10];
          n.cnt = 5'h00;
          // Frames for other ports or devices are dropped so the bus stays free for them.
          if (shifted[13:12] == `MDIO_START && shifted[9:5] == PORT_ADDR &&
              shifted[4:0] == `MGMT_DEVICE_ADDR) begin
            n.state = S_TURN;
          end else begin
            n.state = S_PREAMBLE;
            n.ones  = 6'h00;
          end
        end
      end
      S_TURN: if (rise) begin
        n.cnt = r.cnt + 5'h01;
        if (r.cnt == 5'h00) begin
          if (r.op[1]) begin
            n.mdio_out     = 1'b0;
            n.mdio_drive_n = 1'b0;
            n.shift        = bus.rdata;
          end
        end else begin
          n.state = S_DATA;
          n.cnt   = 5'h00;
          if (r.op[1]) begin
            n.mdio_out = r.shift[15];
            n.shift    = {r.shift[14:0], 1'b0};
          end
        end
      end
      S_DATA: if (rise) begin
        n.cnt = r.cnt + 5'h01;
        if (r.op[1]) begin
          n.mdio_out = r.shift[15];
          n.shift    = {r.shift[14:0], 1'b0};
          if (r.cnt == 5'h0f) begin
            n.mdio_out     = 1'b1;
            n.mdio_drive_n = 1'b1;
            n.state        = S_PREAMBLE;
            n.ones         = 6'h00;
            if (!r.op[0]) n.addr = r.addr + 16'h0001;
          end
        end else begin
          n.shift = shifted;
          if (r.cnt == 5'h0f) begin
            n.state = S_PREAMBLE;
            n.ones  = 6'h00;
            if (r.op == `MDIO_OP_ADDRESS) n.addr = shifted;
            if (r.op == `MDIO_OP_WRITE) begin
              n.wdata = shifted;
              n.wr    = 1'b1;
            end
          end
        end
      end
      default: n.state = S_PREAMBLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r              <= '0;
      r.state        <= S_PREAMBLE;
      r.mdio_out     <= 1'b1;
      r.mdio_drive_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign mdio_out     = r.mdio_out;
  assign mdio_drive_n = r.mdio_drive_n;
  assign bus.addr     = r.addr;
  assign bus.wdata    = r.wdata;
  assign bus.wr       = r.wr;

endmodule

// ---- rtl/serdes_polarity_eq_overlay_regs.sv ----
// Lane polarity, equalizer and status overlay registers behind the management port.
// Assumes fault sources and the ready-in and transmit pins are asynchronous to ref_clk.
`timescale 1ns/10ps
`include "serdes_lane_regs_defs.svh"

module serdes_polarity_eq_overlay_regs
  import serdes_lane_regs_pkg::*;
#(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_drive_n,
  input  wire logic       rx_lane_data,
  output logic            rx_lane_out_positive,
  input  wire logic       tx_lane_in_positive,
  output logic            tx_lane_data,
  output logic            rx_lane_polarity_swap,
  output logic            tx_lane_polarity_swap,
  output logic [3:0]      lane_equalizer_setting,
  output logic            lane_equalizer_adaptive,
  output logic            lane_equalizer_reserved,
  input  wire logic       lane_ready_src,
  output logic            lane_ready_out_pin,
  input  wire logic       lane_ready_in_pin,
  output logic            lane_ready_in_gated,
  input  wire logic       channel_sync_raw,
  output logic            channel_sync_ok,
  input  wire logic       block_lock_lost,
  input  wire logic       bad_codeword,
  input  wire logic       gain_unlock,
  input  wire logic       calib_pending,
  input  wire logic       pll_unlock,
  input  wire logic       signal_loss,
  output logic            fault_indicator_pin
);

  mgmt_reg_if bus ();

  logic engine_out;
  logic engine_drive_n;

  mdio_frame_engine #(
    .PORT_ADDR     (PORT_ADDR),
    .PREAMBLE_BITS (`MDIO_PREAMBLE_BITS)
  ) u_engine (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .mdc          (mdc),
    .mdio_in      (mdio_in),
    .mdio_out     (engine_out),
    .mdio_drive_n (engine_drive_n),
    .bus          (bus.engine)
  );

  // The pin stays with the engine's own flip-flops; no extra stage is inserted.
  assign mdio_out     = engine_out;
  assign mdio_drive_n = engine_drive_n;

  // One decode serves both the write and the read path, so they cannot disagree.
  function automatic logic [1:0] reg_select(input logic [15:0] addr);
    reg_select = 2'b00;
    if (addr == `LANE_CTL_OFFSET) reg_select = 2'b01;
    if (addr == `OVERLAY_CTL_OFFSET) reg_select = 2'b10;
  endfunction

  function automatic logic gate_pin(input logic src, input logic [1:0] code);
    gate_pin = code[0] ? code[1] : src;
  endfunction

  function automatic logic eq_is_reserved(input logic [3:0] code);
    eq_is_reserved = (code > `EQ_ADAPTIVE) && (code < `EQ_STEPPED_FIRST);
  endfunction

  bank_state_s r;
  bank_state_s n;

  // Bit order of the synchronised vector.
  localparam int SY_READY_IN = 7;
  localparam int SY_TX_IN    = 6;

  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic       ready_in_synced;
  logic       tx_in_synced;
  logic [5:0] faults_synced;
  logic       signal_loss_synced;
  logic       ctl_rx_swap;
  logic       ctl_tx_swap;
  logic [3:0] ctl_equalizer;
  logic [1:0] ready_out_pin_gate;
  logic [1:0] ready_in_pin_gate;
  logic       signal_loss_sync_mask;
  logic [5:0] overlay_en;

  // Only second synchroniser stages feed logic; the first stage may still be settling.
  assign ready_in_synced    = r.sync2[SY_READY_IN];
  assign tx_in_synced       = r.sync2[SY_TX_IN];
  assign faults_synced      = r.sync2[5:0];
  assign signal_loss_synced = r.sync2[0];

  assign ctl_rx_swap           = r.lane_ctl[`LANE_RX_SWAP_BIT];
  assign ctl_tx_swap           = r.lane_ctl[`LANE_TX_SWAP_BIT];
  assign ctl_equalizer         = r.lane_ctl[`LANE_EQ_MSB:`LANE_EQ_LSB];
  assign ready_out_pin_gate    = r.overlay_ctl[`OVL_OUT_GATE_MSB:`OVL_OUT_GATE_LSB];
  assign ready_in_pin_gate     = r.overlay_ctl[`OVL_IN_GATE_MSB:`OVL_IN_GATE_LSB];
  assign signal_loss_sync_mask = r.overlay_ctl[`OVL_LOS_MASK_BIT];
  assign overlay_en            = r.overlay_ctl[`OVL_ENABLE_MSB:0];
  assign wr_sel                = bus.wr ? reg_select(bus.addr) : 2'b00;
  assign rd_sel                = reg_select(bus.addr);

  always_comb begin
    n       = r;
    n.sync1 = {lane_ready_in_pin, tx_lane_in_positive, block_lock_lost, bad_codeword,
               gain_unlock, calib_pending, pll_unlock, signal_loss};
    n.sync2 = r.sync1;
    // Reserved lane control fields are stored as written so that software can restore them.
    if (wr_sel[0]) n.lane_ctl = bus.wdata;
    // Bit 6 is never stored, so it reads back as zero whatever was written.
    if (wr_sel[1]) n.overlay_ctl = bus.wdata & `OVERLAY_READ_MASK;
    n.rx_lane_polarity_swap   = ctl_rx_swap;
    n.rx_lane_out_positive    = rx_lane_data ^ ctl_rx_swap;
    n.tx_lane_polarity_swap   = ctl_tx_swap;
    n.tx_lane_data            = tx_in_synced ^ ctl_tx_swap;
    n.lane_equalizer_setting  = ctl_equalizer;
    n.lane_equalizer_adaptive = (ctl_equalizer != `EQ_MAX_GAIN) &&
                                !eq_is_reserved(ctl_equalizer);
    n.lane_equalizer_reserved = eq_is_reserved(ctl_equalizer);
    n.lane_ready_out_pin      = gate_pin(lane_ready_src, ready_out_pin_gate);
    n.lane_ready_in_gated     = gate_pin(ready_in_synced, ready_in_pin_gate);
    n.channel_sync_ok         = channel_sync_raw &
                                (signal_loss_sync_mask | ~signal_loss_synced);
    n.fault_indicator_pin     = |(faults_synced & overlay_en);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r             <= '0;
      r.lane_ctl    <= `LANE_CTL_RESET;
      r.overlay_ctl <= `OVERLAY_CTL_RESET;
    end else begin
      r <= n;
    end
  end

  // Unmapped offsets read as zero rather than aliasing a neighbour.
  always_comb begin
    case (rd_sel)
      2'b01:   bus.rdata = r.lane_ctl;
      2'b10:   bus.rdata = r.overlay_ctl;
      default: bus.rdata = 16'h0000;
    endcase
  end

  assign rx_lane_out_positive    = r.rx_lane_out_positive;
  assign tx_lane_data            = r.tx_lane_data;
  assign rx_lane_polarity_swap   = r.rx_lane_polarity_swap;
  assign tx_lane_polarity_swap   = r.tx_lane_polarity_swap;
  assign lane_equalizer_setting  = r.lane_equalizer_setting;
  assign lane_equalizer_adaptive = r.lane_equalizer_adaptive;
  assign lane_equalizer_reserved = r.lane_equalizer_reserved;
  assign lane_ready_out_pin      = r.lane_ready_out_pin;
  assign lane_ready_in_gated     = r.lane_ready_in_gated;
  assign channel_sync_ok         = r.channel_sync_ok;
  assign fault_indicator_pin     = r.fault_indicator_pin;

endmodule

// ---- verification/serdes_lane_regs_sva.sv ----
// Checker for the lane polarity, equalizer and overlay register block.
// Assumes binding to the block's top module, with one clock domain.
`timescale 1ns/10ps

module serdes_lane_regs_chk
  import serdes_lane_regs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_drive_n,
  input wire logic       rx_lane_data,
  input wire logic       rx_lane_out_positive,
  input wire logic       rx_lane_polarity_swap,
  input wire logic [3:0] lane_equalizer_setting,
  input wire logic       lane_equalizer_adaptive,
  input wire logic       lane_equalizer_reserved,
  input wire logic       channel_sync_raw,
  input wire logic       channel_sync_ok
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_rx_out;
    $past(rstn) |-> rx_lane_out_positive == ($past(rx_lane_data) ^ rx_lane_polarity_swap);
  endproperty
  a_rx_out: assert property (p_rx_out) else $error("rx leg polarity wrong");
  property p_eq_adapt;
    lane_equalizer_adaptive == (lane_equalizer_setting == 4'h1 || lane_equalizer_setting[3]);
  endproperty
  a_eq_adapt: assert property (p_eq_adapt) else $error("adaptive flag wrong");
  property p_eq_rsvd;
    lane_equalizer_reserved == (lane_equalizer_setting inside {[4'h2:4'h7]});
  endproperty
  a_eq_rsvd: assert property (p_eq_rsvd) else $error("reserved code flag wrong");
  property p_sync;
    channel_sync_ok |-> $past(channel_sync_raw);
  endproperty
  a_sync: assert property (p_sync) else $error("sync ok without raw sync");
  property p_eq_write;
    $changed(lane_equalizer_setting) |-> mdio_drive_n;
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("equalizer moved during read");
  property p_drv_run;
    $fell(mdio_drive_n) |-> !mdio_drive_n [*8];
  endproperty
  a_drv_run: assert property (p_drv_run) else $error("read drive too short");
  property p_drv_zero;
    $fell(mdio_drive_n) |-> !mdio_out && $past(mdc, 2);
  endproperty
  a_drv_zero: assert property (p_drv_zero) else $error("turnaround not zero");
  property p_release;
    $rose(mdio_drive_n) |-> $past(mdc, 2);
  endproperty
  a_release: assert property (p_release) else $error("release off clock edge");
endmodule

bind serdes_polarity_eq_overlay_regs serdes_lane_regs_chk chk (.*);

// ---- verification/serdes_polarity_eq_overlay_regs_tb_top.sv ----
// Bench for the lane polarity, equalizer and overlay registers over the management port.
// Assumes the default port address and a pull-up on the management data line.
`timescale 1ns/10ps
`include "serdes_lane_regs_defs.svh"

module serdes_polarity_eq_overlay_regs_tb_top
  import serdes_lane_regs_pkg::*;
;
  logic        ref_clk, rstn, mdc, mdio_in, host_bit, rx_lane_data, tx_lane_in_positive;
  logic        lane_ready_src, lane_ready_in_pin, channel_sync_raw, block_lock_lost;
  logic        bad_codeword, gain_unlock, calib_pending, pll_unlock, signal_loss;
  logic        mdio_out, mdio_drive_n, rx_lane_out_positive, tx_lane_data;
  logic        rx_lane_polarity_swap, tx_lane_polarity_swap, lane_equalizer_adaptive;
  logic        lane_equalizer_reserved, lane_ready_out_pin, lane_ready_in_gated;
  logic        channel_sync_ok, fault_indicator_pin;
  logic [3:0]  lane_equalizer_setting;
  logic [15:0] q, v;
  int          error_cnt, checks;

  // A released line floats to the pull-up level through host_bit held high.
  assign mdio_in = mdio_drive_n ? host_bit : mdio_out;

  serdes_polarity_eq_overlay_regs dut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Ten reference clocks per management bit keeps well above the minimum period.
  task automatic bit_cyc(input logic b, output logic s);
    @(posedge ref_clk);
    mdc <= 1'b0;
    host_bit <= b;
    repeat (5) @(posedge ref_clk);
    s = mdio_in;
    mdc <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [15:0] d);
    logic [15:0] h;
    logic        s;
    h = {2'b00, op, 5'h00, `MGMT_DEVICE_ADDR, 2'b10};
    for (int i = 0; i < 32; i++) begin
      bit_cyc(1'b1, s);
    end
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(h[i] | (i < 2 && op[1]), s);
    end
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(d[i] | op[1], s);
      q[i] = s;
    end
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    frame(2'b00, a);
    frame(2'b01, d);
  endtask

  task automatic rd(input logic [15:0] a);
    frame(2'b00, a);
    frame(2'b11, 16'h0000);
  endtask

  initial begin
    rstn = 1'b0;
    mdc = 1'b0;
    host_bit = 1'b1;
    rx_lane_data = 1'b1;
    tx_lane_in_positive = 1'b1;
    lane_ready_src = 1'b1;
    lane_ready_in_pin = 1'b1;
    channel_sync_raw = 1'b1;
    {block_lock_lost, bad_codeword, gain_unlock, calib_pending, pll_unlock, signal_loss} = 6'h01;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`LANE_CTL_OFFSET);
    check("ctl_reset", q, 16'h000d);
    rd(`OVERLAY_CTL_OFFSET);
    check("ovl_reset", q, 16'h0380);
    check("sync_reset", 16'(channel_sync_ok), 16'h0001);
    check("fault_reset", 16'(fault_indicator_pin), 16'h0000);
    for (int c = 0; c < 16; c++) begin
      rx_lane_data <= c[2];
      tx_lane_in_positive <= c[3];
      v = {c[0], c[1], c[3:2], c[3:0], 8'h0d ^ c[7:0]};
      wr(`LANE_CTL_OFFSET, v);
      rd(`LANE_CTL_OFFSET);
      check("ctl", q, v);
      check("eq", 16'(lane_equalizer_setting), 16'(c));
      check("adapt", 16'(lane_equalizer_adaptive), 16'(c == 1 || c > 7));
      check("rsvd", 16'(lane_equalizer_reserved), 16'(c > 1 && c < 8));
      check("rx", 16'(rx_lane_out_positive), 16'(c[2] ^ c[0]));
      check("tx", 16'(tx_lane_data), 16'(c[3] ^ c[1]));
      check("rx_swap", 16'(rx_lane_polarity_swap), 16'(c[0]));
      check("tx_swap", 16'(tx_lane_polarity_swap), 16'(c[1]));
    end
    for (int i = 0; i < 8; i++) begin
      {block_lock_lost, bad_codeword, gain_unlock, calib_pending, pll_unlock, signal_loss} <=
        i[2] ? 6'h15 : 6'h2a;
      lane_ready_src <= !i[1];
      lane_ready_in_pin <= !i[1];
      channel_sync_raw <= (i != 2);
      v = {i[1:0], i[1:0], 4'h3, i[1], 1'b1, i[0] ? 6'h15 : 6'h2a};
      wr(`OVERLAY_CTL_OFFSET, v);
      rd(`OVERLAY_CTL_OFFSET);
      check("ovl", q, v & `OVERLAY_READ_MASK);
      check("rdy_out", 16'(lane_ready_out_pin), 16'(i[0] ? i[1] : !i[1]));
      check("rdy_in", 16'(lane_ready_in_gated), 16'(i[0] ? i[1] : !i[1]));
      check("sync", 16'(channel_sync_ok), 16'(i != 2 && (i[1] || !i[2])));
      check("fault", 16'(fault_indicator_pin), 16'(i[2] == i[0]));
    end
    wr(16'h000a, 16'hffff);
    rd(16'h000a);
    check("unmapped", q, 16'h0000);
    rd(`LANE_CTL_OFFSET);
    check("ctl_kept", q, 16'hff02);
    finish_test;
  end
endmodule
